// >>> ands_exec.sv
/*
 * Execution datapath for literal AND, accumulator-file AND, bit clear and
 * bit set, one instruction per enabled clock.
 * Assumes the core presents the file register addressed by the instruction
 * on file_rdata_in in the same cycle, and writes back from file_we_out.
 */
// What this block does
// - Literal AND: accumulator AND literal into accumulator, zero flag updated, one cycle.
// - File AND: accumulator AND addressed register, only zero flag affected, one cycle.
// - File AND destination zero writes accumulator; destination one writes the register.
// - Bit clear forces selected register bit low, flags untouched, one cycle.
// - Bit set forces selected register bit high, flags untouched, one cycle.
// - Operations reading the I/O port register use sensed pin levels.
// - Writing the timer count register clears prescaler when assigned to it.
`include "ands_consts.svh"

module ands_exec (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic instr_valid_in,
    input wire logic [11:0] instr_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic [7:0] port_pins_in,
    input wire logic prescaler_on_timer_in,
    output logic [7:0] accum_out,
    output logic zero_flag_out,
    output logic file_we_out,
    output logic [4:0] file_waddr_out,
    output logic [7:0] file_wdata_out,
    output logic prescaler_clr_out
);
    // ======================================================================
    // Pin synchroniser
    ands_pkg::ands_byte_t pins_s1_reg, pins_s1_next;
    ands_pkg::ands_byte_t pins_s2_reg, pins_s2_next;

    always_comb begin
        pins_s1_next = pins_s1_reg;
        pins_s2_next = pins_s2_reg;
        if (ce_in) begin
            pins_s1_next = port_pins_in;
            pins_s2_next = pins_s1_reg;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pins_s1_reg <= `ANDS_BYTE_ZERO;
            pins_s2_reg <= `ANDS_BYTE_ZERO;
        end else begin
            pins_s1_reg <= pins_s1_next;
            pins_s2_reg <= pins_s2_next;
        end
    end

    // ======================================================================
    // Decode
    ands_pkg::ands_op_e op;
    ands_pkg::ands_addr_t addr;
    logic [2:0] bit_idx;
    logic dest_file;
    ands_pkg::ands_byte_t literal;

    assign addr = instr_in[`ANDS_ADDR_MSB:0];
    assign bit_idx = instr_in[`ANDS_IDX_MSB:`ANDS_IDX_LSB];
    assign dest_file = instr_in[`ANDS_DEST_BIT];
    assign literal = instr_in[`ANDS_LIT_MSB:0];

    always_comb begin
        op = ands_pkg::ANDS_OP_NONE;
        if (instr_valid_in) begin
            if (instr_in[`ANDS_TOP_MSB:`ANDS_TOP_LSB] == `ANDS_OPC_LIT) begin
                op = ands_pkg::ANDS_OP_LIT;
            end else if (instr_in[`ANDS_TOP_MSB:`ANDS_PFX_LSB] == `ANDS_OPC_ANDF) begin
                op = ands_pkg::ANDS_OP_ANDF;
            end else if (instr_in[`ANDS_TOP_MSB:`ANDS_TOP_LSB] == `ANDS_OPC_BCLR) begin
                op = ands_pkg::ANDS_OP_BCLR;
            end else if (instr_in[`ANDS_TOP_MSB:`ANDS_TOP_LSB] == `ANDS_OPC_BSET) begin
                op = ands_pkg::ANDS_OP_BSET;
            end
        end
    end

    // ======================================================================
    // Operand and results
    // The pins lag by two clocks; a pin that moves just before the read is
    // seen at its older level, which is the usual price of a safe crossing.
    ands_pkg::ands_byte_t operand;
    ands_pkg::ands_byte_t and_file_res;
    ands_pkg::ands_byte_t bit_res;

    assign operand = (addr == `ANDS_ADDR_PORT) ? pins_s2_reg : file_rdata_in;
    assign and_file_res = accum_out & operand;

    ands_bit_mod u_bit_mod (
        .data_in(operand),
        .index_in(bit_idx),
        .set_in(op == ands_pkg::ANDS_OP_BSET),
        .data_out(bit_res)
    );

    // ======================================================================
    // Architectural state
    ands_pkg::ands_byte_t accum_reg, accum_next;
    logic zero_reg, zero_next;
    logic we_reg, we_next;
    ands_pkg::ands_addr_t waddr_reg, waddr_next;
    ands_pkg::ands_byte_t wdata_reg, wdata_next;
    logic pclr_reg, pclr_next;

    always_comb begin
        accum_next = accum_reg;
        zero_next = zero_reg;
        we_next = we_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        pclr_next = pclr_reg;
        if (ce_in) begin
            we_next = 1'b0;
            pclr_next = 1'b0;
            unique case (op)
                ands_pkg::ANDS_OP_NONE: begin
                end
                ands_pkg::ANDS_OP_LIT: begin
                    accum_next = accum_reg & literal;
                    zero_next = ((accum_reg & literal) == `ANDS_BYTE_ZERO);
                end
                ands_pkg::ANDS_OP_ANDF: begin
                    zero_next = (and_file_res == `ANDS_BYTE_ZERO);
                    if (dest_file) begin
                        we_next = 1'b1;
                        waddr_next = addr;
                        wdata_next = and_file_res;
                        pclr_next = (addr == `ANDS_ADDR_TIMER) && prescaler_on_timer_in;
                    end else begin
                        accum_next = and_file_res;
                    end
                end
                ands_pkg::ANDS_OP_BCLR, ands_pkg::ANDS_OP_BSET: begin
                    // Flags untouched by either bit operation
                    we_next = 1'b1;
                    waddr_next = addr;
                    wdata_next = bit_res;
                    pclr_next = (addr == `ANDS_ADDR_TIMER) && prescaler_on_timer_in;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            accum_reg <= `ANDS_ACC_RST;
            zero_reg <= `ANDS_ZERO_RST;
            we_reg <= 1'b0;
            waddr_reg <= `ANDS_ADDR_RST;
            wdata_reg <= `ANDS_BYTE_ZERO;
            pclr_reg <= 1'b0;
        end else begin
            accum_reg <= accum_next;
            zero_reg <= zero_next;
            we_reg <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            pclr_reg <= pclr_next;
        end
    end

    assign accum_out = accum_reg;
    assign zero_flag_out = zero_reg;
    assign file_we_out = we_reg;
    assign file_waddr_out = waddr_reg;
    assign file_wdata_out = wdata_reg;
    assign prescaler_clr_out = pclr_reg;

    // ======================================================================
    // Assertions
    logic go;
    assign go = ce_in && instr_valid_in;

    a_lit_and_result: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_LIT) |=> accum_out == ($past(accum_out)
            & $past(literal)) && zero_flag_out == ((accum_out) == `ANDS_BYTE_ZERO)
            && !file_we_out)
        else $error("literal AND result or zero flag wrong");

    a_file_and_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_ANDF) |=>
            zero_flag_out == ($past(and_file_res) == `ANDS_BYTE_ZERO))
        else $error("zero flag does not match file AND result");

    a_file_and_accum: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_ANDF && !dest_file) |=>
            accum_out == ($past(accum_out) & $past(operand)) && !file_we_out)
        else $error("file AND to accumulator wrong");

    a_file_and_dest: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_ANDF && dest_file) |=> file_we_out
            && file_waddr_out == $past(addr) && accum_out == $past(accum_out)
            && file_wdata_out == ($past(accum_out) & $past(operand)))
        else $error("file AND write-back wrong");

    a_bit_clear_write: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_BCLR) |=> file_we_out
            && file_wdata_out == ($past(operand) & ~(8'h01 << $past(bit_idx)))
            && $stable(zero_flag_out) && $stable(accum_out))
        else $error("bit clear wrong");

    a_bit_set_write: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_BSET) |=> file_we_out
            && file_wdata_out == ($past(operand) | (8'h01 << $past(bit_idx)))
            && $stable(zero_flag_out) && file_waddr_out == $past(addr))
        else $error("bit set wrong");

    a_port_uses_pins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (go && op == ands_pkg::ANDS_OP_ANDF && dest_file && addr == `ANDS_ADDR_PORT)
            |=> file_wdata_out == ($past(accum_out) & $past(pins_s2_reg)))
        else $error("port operand not taken from pins");

    a_timer_prescale_clr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && $past(ce_in)) |-> prescaler_clr_out == ($past(instr_valid_in)
            && $past(prescaler_on_timer_in) && $past(addr) == `ANDS_ADDR_TIMER
            && ($past(op) == ands_pkg::ANDS_OP_BCLR || $past(op) == ands_pkg::ANDS_OP_BSET
            || ($past(op) == ands_pkg::ANDS_OP_ANDF && $past(dest_file)))))
        else $error("prescaler clear mismatch");

    a_idle_no_write: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && !instr_valid_in) |=> !file_we_out && !prescaler_clr_out
            && $stable(accum_out))
        else $error("write without instruction");

    c_lit_zero: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        go && op == ands_pkg::ANDS_OP_LIT ##1 zero_flag_out);
    c_file_dest: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        go && op == ands_pkg::ANDS_OP_ANDF && dest_file);
    c_bit_ops_b2b: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        go && op == ands_pkg::ANDS_OP_BSET ##1 go && op == ands_pkg::ANDS_OP_BCLR);
    c_prescale_clr: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        prescaler_clr_out);
endmodule

// >>> ands_consts.svh
/*
 * Constants for the AND and bit-modify execution datapath: opcode fields,
 * register addresses and reset values.
 * Assumes 12-bit instruction words and an 8-bit, 32-entry file register space.
 */
`ifndef ANDS_CONSTS_SVH
`define ANDS_CONSTS_SVH

// ==========================================================================
// Instruction fields
`define ANDS_TOP_MSB 11
`define ANDS_TOP_LSB 8
`define ANDS_PFX_LSB 6
`define ANDS_DEST_BIT 5
`define ANDS_IDX_MSB 7
`define ANDS_IDX_LSB 5
`define ANDS_ADDR_MSB 4
`define ANDS_LIT_MSB 7

// ==========================================================================
// Opcode values
`define ANDS_OPC_LIT 4'he
`define ANDS_OPC_BCLR 4'h4
`define ANDS_OPC_BSET 4'h5
`define ANDS_OPC_ANDF 6'h05

// ==========================================================================
// Special file register addresses
`define ANDS_ADDR_TIMER 5'h01
`define ANDS_ADDR_PORT 5'h06

// ==========================================================================
// Reset values
`define ANDS_ACC_RST 8'h00
`define ANDS_ADDR_RST 5'h00
`define ANDS_ZERO_RST 1'b0
`define ANDS_BYTE_ZERO 8'h00

`endif

// >>> ands_pkg.sv
/*
 * Types shared by the AND and bit-modify datapath.
 * Assumes nothing of its surroundings.
 */
package ands_pkg;
    typedef logic [7:0] ands_byte_t;
    typedef logic [4:0] ands_addr_t;
    typedef enum logic [2:0] {
        ANDS_OP_NONE = 3'b000,
        ANDS_OP_LIT = 3'b001,
        ANDS_OP_ANDF = 3'b010,
        ANDS_OP_BCLR = 3'b011,
        ANDS_OP_BSET = 3'b100
    } ands_op_e;
endpackage

// >>> ands_bit_mod.sv
/*
 * Single-bit force of a byte: clears or sets the indexed bit.
 * Assumes a combinational caller; the result is registered outside.
 */
module ands_bit_mod (
    input wire logic [7:0] data_in,
    input wire logic [2:0] index_in,
    input wire logic set_in,
    output logic [7:0] data_out
);
    // ======================================================================
    // Bit force
    always_comb begin
        data_out = data_in;
        data_out[index_in] = set_in;
    end
endmodule

// >>> ands_exec_tb.sv
/*
 * Self-checking testbench for the AND and bit-modify datapath.
 * Assumes the core-side file array is played by the bench itself:
 * every read operand but the port's is driven on file_rdata_in in the cycle it is needed.
 */
`include "ands_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [11:0] ins;
        logic [7:0] rd;
        logic pt;
        logic we;
        logic [7:0] wd;
        logic z;
        logic pc;
    } ands_row_s;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic [11:0] instr_in = 12'h000;
    logic [7:0] file_rdata_in = 8'h00;
    logic [7:0] port_pins_in = 8'h3c;
    logic prescaler_on_timer_in = 1'b0;
    logic [7:0] accum_out;
    logic zero_flag_out;
    logic file_we_out;
    logic [4:0] file_waddr_out;
    logic [7:0] file_wdata_out;
    logic prescaler_clr_out;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    ands_row_s rows [11];

    ands_exec ands_exec_inst (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .instr_valid_in(instr_valid_in),
        .instr_in(instr_in),
        .file_rdata_in(file_rdata_in),
        .port_pins_in(port_pins_in),
        .prescaler_on_timer_in(prescaler_on_timer_in),
        .accum_out(accum_out),
        .zero_flag_out(zero_flag_out),
        .file_we_out(file_we_out),
        .file_waddr_out(file_waddr_out),
        .file_wdata_out(file_wdata_out),
        .prescaler_clr_out(prescaler_clr_out)
    );

    // ======================================================================
    // Clock and timeout
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end

    // ======================================================================
    // Helpers
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Accumulator can only stay at its reset value: no load op lives here
    task automatic run(input ands_row_s r);
        @(posedge clock_in);
        instr_in <= r.ins;
        file_rdata_in <= r.rd;
        prescaler_on_timer_in <= r.pt;
        instr_valid_in <= 1'b1;
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        #1;
        cmp(accum_out, 8'h00);
        cmp({7'h00, zero_flag_out}, {7'h00, r.z});
        cmp({7'h00, file_we_out}, {7'h00, r.we});
        cmp({7'h00, prescaler_clr_out}, {7'h00, r.pc});
        if (r.we) begin
            cmp({3'h0, file_waddr_out}, {3'h0, r.ins[4:0]});
            cmp(file_wdata_out, r.wd);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        rows[0] = '{12'h5ea, 8'h0a, 1'b0, 1'b1, 8'h8a, 1'b0, 1'b0};
        rows[1] = '{12'h4ea, 8'hc7, 1'b0, 1'b1, 8'h47, 1'b0, 1'b0};
        rows[2] = '{12'he5f, 8'hff, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0};
        rows[3] = '{12'h51f, 8'h00, 1'b0, 1'b1, 8'h01, 1'b1, 1'b0};
        rows[4] = '{12'h16a, 8'hc2, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0};
        rows[5] = '{12'h14a, 8'hc2, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0};
        rows[6] = '{12'h421, 8'hff, 1'b1, 1'b1, 8'hfd, 1'b1, 1'b1};
        rows[7] = '{12'h421, 8'hff, 1'b0, 1'b1, 8'hfd, 1'b1, 1'b0};
        rows[8] = '{12'h161, 8'hff, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1};
        rows[9] = '{12'h141, 8'hff, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0};
        rows[10] = '{12'hc55, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0};
        repeat (2) @(posedge clock_in);
        #1;
        cmp({7'h00, file_we_out, accum_out, 3'h0, file_waddr_out}, 24'h0);
        cmp({file_wdata_out, 6'h00, zero_flag_out, prescaler_clr_out}, 16'h0);
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        foreach (rows[i]) run(rows[i]);
        // Every bit index, both polarities
        for (int b = 0; b < 8; b++) begin
            run('{{4'h5, b[2:0], 5'h0b}, 8'h00, 1'b0, 1'b1, 8'h01 << b, 1'b1, 1'b0});
            run('{{4'h4, b[2:0], 5'h0b}, 8'hff, 1'b0, 1'b1, ~(8'h01 << b), 1'b1, 1'b0});
        end
        // Port operand comes from the pins, not the latch value offered
        run('{12'h506, 8'hc0, 1'b0, 1'b1, 8'h3d, 1'b1, 1'b0});
        run('{12'h166, 8'hff, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0});
        // Frozen clock enable ignores a valid instruction
        @(posedge clock_in);
        ce_in <= 1'b0;
        instr_in <= 12'h5e5;
        instr_valid_in <= 1'b1;
        @(posedge clock_in);
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        ce_in <= 1'b1;
        #1;
        cmp({7'h00, file_we_out}, 8'h00);
        // Reset in mid-run clears a write pulse that a low enable holds high
        @(posedge clock_in);
        instr_in <= rows[6].ins;
        file_rdata_in <= rows[6].rd;
        prescaler_on_timer_in <= rows[6].pt;
        instr_valid_in <= 1'b1;
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        ce_in <= 1'b0;
        #1;
        cmp({7'h00, file_we_out}, 8'h01);
        cmp({7'h00, prescaler_clr_out}, 8'h01);
        cmp({7'h00, zero_flag_out}, 8'h01);
        cmp({3'h0, file_waddr_out}, {3'h0, `ANDS_ADDR_TIMER});
        cmp(file_wdata_out, rows[6].wd);
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        ce_in <= 1'b1;
        #1;
        cmp({7'h00, file_we_out}, 8'h00);
        cmp({7'h00, prescaler_clr_out}, 8'h00);
        cmp(file_wdata_out, 8'h00);
        cmp({3'h0, file_waddr_out}, 8'h00);
        cmp({7'h00, zero_flag_out}, 8'h00);
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        run(rows[0]);
        results();
    end
endmodule
